// ===== afc_host.v
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "afc_defs.vh"

// How it works
// R1: Framing mode field selects 1 plain or 2 escaped framing.
// R2: Receiver ignores all bytes until a 0x7E start delimiter arrives.
// R3: Device answers a bad frame with a status frame naming the failure.
// R4: Escaped mode: reserved byte becomes 0x7D then byte XOR 0x20, reversed on receive.
// R5: Reserved bytes are 0x7E, 0x7D, 0x11 and 0x13.
// R6: Length counts unescaped frame-data bytes only.
// R7: Checksum works on unescaped values; escaping after, unescaping before.
// R8: Sender checksum is 0xFF minus low 8 bits of frame-data sum.
// R9: Receiver accepts when data sum plus checksum equals 0xFF.
// R10: First frame-data byte is the frame type, payload follows.
// R11: Multi-byte values, length included, go most significant byte first.
// R12: Device sends type 0x8A status frames on its own.
// R13: Type 0x08 frame: id byte 5, command bytes 6-7, optional value after.
// R14: Zero frame id gets no response; nonzero id is echoed.
// R15: Host ends label, discovery and address-high strings with 0x00.
// R16: Type 0x09 values stay pending until a 0x08 frame or commit.
// R17: Device answers local commands with one or more 0x88 frames.
// R18: Device sends a 0x97 frame per remote response after a 0x17.
// R19: Type 0x10 sends payload by radio; 0x11 adds endpoint and cluster.
// R20: Device reports transmit completion with a 0x8B frame.
// R21: Received packets arrive as 0x90 or 0x91 per receive format.
// R22: Samples come as 0x94, node identification as 0x95 frames.
// R23: A frame failing checksum is dropped; hunting restarts.
// R24: Plain mode takes every byte after length literally.
module afc_host
(
	input  wire        core_clk,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [7:0]  tx_byte,
	output reg         tx_valid,
	input  wire        tx_ready,
	input  wire [7:0]  rx_byte,
	input  wire        rx_valid
);

	localparam TX_IDLE  = 3'h0;
	localparam TX_DELIM = 3'h1;
	localparam TX_LENH  = 3'h2;
	localparam TX_LENL  = 3'h3;
	localparam TX_DATA  = 3'h4;
	localparam TX_CK    = 3'h5;

	localparam RX_HUNT  = 3'h0;
	localparam RX_LENH  = 3'h1;
	localparam RX_LENL  = 3'h2;
	localparam RX_DATA  = 3'h3;
	localparam RX_CK    = 3'h4;

	reg  [7:0]              tx_mem [0:63];
	reg  [7:0]              rx_mem [0:63];
	reg  [1:0]              mode;
	reg                     nul_en;
	reg  [15:0]             tx_len;
	reg  [`AFC_BUF_AW-1:0]  wr_ptr;
	reg  [`AFC_BUF_AW-1:0]  rd_ptr;
	reg  [2:0]              tx_st;
	reg  [15:0]             tx_idx;
	reg  [7:0]              tx_sum;
	reg                     tx_esc;
	reg                     tx_nul;
	reg  [7:0]              tx_raw;
	reg                     tx_done;
	reg  [2:0]              rx_st;
	reg  [15:0]             rx_cnt;
	reg  [15:0]             rx_idx;
	reg  [7:0]              rx_sum;
	reg                     rx_esc;
	reg  [15:0]             rx_len;
	reg  [7:0]              rx_type;
	reg  [7:0]              rx_id;
	reg  [7:0]              cur_type;
	reg  [7:0]              cur_id;
	reg                     rx_ready;
	reg                     ck_err;
	reg                     overrun;
	reg                     stat_seen;
	reg                     ev_ok;
	reg                     ev_err;
	reg                     ev_ovr;
	reg                     ev_stat;
	reg  [7:0]              rx_val;
	wire                    wr_acc;
	wire                    rd_acc;
	wire                    setup;
	wire                    mapped;
	wire                    esc_mode;
	wire                    tx_load;
	wire                    need_esc;
	wire [15:0]             tx_total;
	wire                    start_ok;
	wire                    tx_busy;
	wire                    w1c;
	wire                    rx_take;
	wire [7:0]              rx_raw_sum;

	// APB slave answers in its first access cycle
	assign pready   = 1'b1;
	assign setup    = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && penable && !pwrite;
	assign mapped   = (paddr == `AFC_REG_CTRL) || (paddr == `AFC_REG_STATUS) ||
		(paddr == `AFC_REG_TX_LEN) || (paddr == `AFC_REG_TX_DATA) ||
		(paddr == `AFC_REG_RX_LEN) || (paddr == `AFC_REG_RX_DATA) ||
		(paddr == `AFC_REG_RX_INFO);
	assign pslverr  = psel && penable && !mapped;
	assign w1c      = wr_acc && (paddr == `AFC_REG_STATUS);
	assign esc_mode = (mode == `AFC_MODE_ESCAPED); // [R1]
	assign tx_busy  = (tx_st != TX_IDLE) || tx_valid;
	assign tx_total = tx_len + {15'h0000, nul_en}; // [R6] [R15]
	// Zero or oversized frames cannot be sent from the buffer, so start is dropped
	assign start_ok = wr_acc && (paddr == `AFC_REG_CTRL) && pwdata[`AFC_CTRL_START] &&
		!tx_busy && (tx_total != 16'h0000) && (tx_total <= `AFC_BUF_DEPTH);

	// Read data latched in setup so prdata comes from a flop
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
		begin
			case (paddr)
				`AFC_REG_CTRL:    prdata <= {29'h0000_0000, nul_en, mode};
				`AFC_REG_STATUS:  prdata <= {26'h0000_000, stat_seen, tx_done, overrun,
					ck_err, rx_ready, tx_busy};
				`AFC_REG_TX_LEN:  prdata <= {16'h0000, tx_len};
				`AFC_REG_RX_LEN:  prdata <= {16'h0000, rx_len};
				`AFC_REG_RX_DATA: prdata <= {24'h00_0000, rx_mem[rd_ptr]};
				`AFC_REG_RX_INFO: prdata <= {16'h0000, rx_id, rx_type};
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control registers and buffer pointers
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode   <= `AFC_CTRL_RESET; // Plain framing out of reset [R1]
			nul_en <= 1'b0;
			tx_len <= 16'h0000;
			wr_ptr <= 6'h00;
			rd_ptr <= 6'h00;
		end
		else
		begin
			if (wr_acc && (paddr == `AFC_REG_CTRL))
			begin
				mode   <= pwdata[`AFC_CTRL_MODE_MSB:`AFC_CTRL_MODE_LSB]; // [R1]
				nul_en <= pwdata[`AFC_CTRL_NUL_BIT];
			end
			// Writing the length rewinds the fill pointer for a new frame
			if (wr_acc && (paddr == `AFC_REG_TX_LEN))
			begin
				tx_len <= pwdata[15:0];
				wr_ptr <= 6'h00;
			end
			else if (wr_acc && (paddr == `AFC_REG_TX_DATA) && !tx_busy)
				wr_ptr <= wr_ptr + 6'h01;
			// Each data read pops one byte; a fresh frame rewinds it
			if (ev_ok)
				rd_ptr <= 6'h00;
			else if (rd_acc && (paddr == `AFC_REG_RX_DATA))
				rd_ptr <= rd_ptr + 6'h01;
		end
	end

	// Transmit buffer is frozen while a frame goes out
	always @(posedge core_clk)
	begin
		if (wr_acc && (paddr == `AFC_REG_TX_DATA) && !tx_busy)
			tx_mem[wr_ptr] <= pwdata[7:0]; // [R10] [R13]
	end

	// Raw byte for the current transmit field
	always @*
	begin
		tx_raw = `AFC_DELIM;
		case (tx_st)
			TX_DELIM: tx_raw = `AFC_DELIM;
			TX_LENH:  tx_raw = tx_total[15:8]; // [R11]
			TX_LENL:  tx_raw = tx_total[7:0];
			TX_DATA:  tx_raw = tx_nul ? `AFC_NUL : tx_mem[tx_idx[`AFC_BUF_AW-1:0]]; // [R15]
			TX_CK:    tx_raw = `AFC_CK_GOOD - tx_sum; // [R8]
			default:  tx_raw = `AFC_DELIM;
		endcase
	end

	assign tx_load  = (tx_st != TX_IDLE) && (!tx_valid || tx_ready);
	// Only the leading delimiter goes out unescaped
	assign need_esc = esc_mode && (tx_st != TX_DELIM) && ((tx_raw == `AFC_DELIM) ||
		(tx_raw == `AFC_ESC) || (tx_raw == `AFC_XON) || (tx_raw == `AFC_XOFF)); // [R5]

	// Transmit framer
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_st    <= TX_IDLE;
			tx_idx   <= 16'h0000;
			tx_sum   <= 8'h00;
			tx_esc   <= 1'b0;
			tx_nul   <= 1'b0;
			tx_byte  <= 8'h00;
			tx_valid <= 1'b0;
			tx_done  <= 1'b0;
		end
		else
		begin
			if (w1c && pwdata[`AFC_ST_TX_DONE])
				tx_done <= 1'b0;
			if (start_ok)
				tx_st <= TX_DELIM;
			if (tx_load)
			begin
				tx_valid <= 1'b1;
				if (need_esc && !tx_esc)
				begin
					tx_byte <= `AFC_ESC; // [R4]
					tx_esc  <= 1'b1;
				end
				else
				begin
					tx_byte <= tx_esc ? (tx_raw ^ `AFC_ESC_XOR) : tx_raw; // [R4] [R7]
					tx_esc  <= 1'b0;
					case (tx_st)
						TX_DELIM: tx_st <= TX_LENH;
						TX_LENH:  tx_st <= TX_LENL;
						TX_LENL:
						begin
							tx_st  <= TX_DATA;
							tx_idx <= 16'h0000;
							tx_sum <= 8'h00;
							tx_nul <= (tx_len == 16'h0000);
						end
						TX_DATA:
						begin
							tx_sum <= tx_sum + tx_raw; // [R7] [R8]
							tx_idx <= tx_idx + 16'h0001;
							tx_nul <= nul_en && (tx_idx + 16'h0001 == tx_len);
							if (tx_idx == tx_total - 16'h0001)
								tx_st <= TX_CK;
						end
						TX_CK:
						begin
							tx_st   <= TX_IDLE;
							tx_done <= 1'b1;
						end
						default:  tx_st <= TX_IDLE;
					endcase
				end
			end
			else if (tx_ready)
				tx_valid <= 1'b0;
		end
	end

	// Plain mode takes bytes literally; escaped mode strips the flag byte
	assign rx_take    = rx_valid && !(esc_mode && (rx_byte == `AFC_ESC)) &&
		!(esc_mode && (rx_byte == `AFC_DELIM)); // [R24]
	assign rx_raw_sum = rx_sum + rx_val;

	always @*
	begin
		rx_val = rx_esc ? (rx_byte ^ `AFC_ESC_XOR) : rx_byte; // [R4] [R7]
	end

	// Receive deframer
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_st    <= RX_HUNT;
			rx_cnt   <= 16'h0000;
			rx_idx   <= 16'h0000;
			rx_sum   <= 8'h00;
			rx_esc   <= 1'b0;
			cur_type <= 8'h00;
			cur_id   <= 8'h00;
			ev_ok    <= 1'b0;
			ev_err   <= 1'b0;
			ev_ovr   <= 1'b0;
			ev_stat  <= 1'b0;
		end
		else
		begin
			ev_ok   <= 1'b0;
			ev_err  <= 1'b0;
			ev_ovr  <= 1'b0;
			ev_stat <= 1'b0;
			if (rx_valid && esc_mode && (rx_byte == `AFC_DELIM))
			begin
				// A bare delimiter can only open a frame, so resync on it
				ev_err <= (rx_st != RX_HUNT);
				rx_st  <= RX_LENH;
				rx_esc <= 1'b0;
			end
			else if (rx_valid && esc_mode && (rx_byte == `AFC_ESC) && (rx_st != RX_HUNT))
				rx_esc <= 1'b1; // [R4]
			else if (rx_take)
			begin
				rx_esc <= 1'b0;
				case (rx_st)
					RX_HUNT:
						if (rx_byte == `AFC_DELIM)
							rx_st <= RX_LENH; // [R2]
					RX_LENH:
					begin
						rx_cnt[15:8] <= rx_val; // [R11]
						rx_st        <= RX_LENL;
					end
					RX_LENL:
					begin
						rx_cnt[7:0] <= rx_val;
						rx_idx      <= 16'h0000;
						rx_sum      <= 8'h00;
						rx_st       <= ({rx_cnt[15:8], rx_val} == 16'h0000) ? RX_HUNT : RX_DATA;
					end
					RX_DATA:
					begin
						rx_sum <= rx_raw_sum; // [R6] [R9]
						rx_idx <= rx_idx + 16'h0001;
						if (rx_idx == 16'h0000)
							cur_type <= rx_val; // [R10]
						if (rx_idx == 16'h0001)
							cur_id <= rx_val; // [R14]
						if (rx_idx == rx_cnt - 16'h0001)
							rx_st <= RX_CK;
					end
					RX_CK:
					begin
						rx_st <= RX_HUNT;
						if (rx_raw_sum != `AFC_CK_GOOD)
							ev_err <= 1'b1; // [R9] [R23]
						else if (rx_ready || (rx_cnt > `AFC_BUF_DEPTH))
							ev_ovr <= 1'b1;
						else
						begin
							ev_ok   <= 1'b1;
							ev_stat <= (cur_type == `AFC_TYPE_STATUS); // [R12]
						end
					end
					default: rx_st <= RX_HUNT;
				endcase
			end
		end
	end

	// Receive buffer only fills while software has released it
	always @(posedge core_clk)
	begin
		if (rx_take && (rx_st == RX_DATA) && !rx_ready && (rx_idx < `AFC_BUF_DEPTH))
			rx_mem[rx_idx[`AFC_BUF_AW-1:0]] <= rx_val;
	end

	// Sticky status, set beats a same-cycle clear
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_ready  <= 1'b0;
			ck_err    <= 1'b0;
			overrun   <= 1'b0;
			stat_seen <= 1'b0;
			rx_len    <= 16'h0000;
			rx_type   <= 8'h00;
			rx_id     <= 8'h00;
		end
		else
		begin
			rx_ready  <= ev_ok || (rx_ready && !(w1c && pwdata[`AFC_ST_RX_READY]));
			ck_err    <= ev_err || (ck_err && !(w1c && pwdata[`AFC_ST_CK_ERR])); // [R23]
			overrun   <= ev_ovr || (overrun && !(w1c && pwdata[`AFC_ST_OVERRUN]));
			stat_seen <= ev_stat || (stat_seen && !(w1c && pwdata[`AFC_ST_STAT_SEEN]));
			if (ev_ok)
			begin
				rx_len  <= rx_cnt;
				rx_type <= cur_type; // [R10]
				rx_id   <= cur_id; // [R14]
			end
		end
	end

endmodule // afc_host

// ===== afc_defs.vh
`ifndef AFC_DEFS_VH
`define AFC_DEFS_VH

// Register byte offsets
`define AFC_REG_CTRL      8'h00
`define AFC_REG_STATUS    8'h04
`define AFC_REG_TX_LEN    8'h08
`define AFC_REG_TX_DATA   8'h0C
`define AFC_REG_RX_LEN    8'h10
`define AFC_REG_RX_DATA   8'h14
`define AFC_REG_RX_INFO   8'h18

// Control fields
`define AFC_CTRL_MODE_LSB 0
`define AFC_CTRL_MODE_MSB 1
`define AFC_CTRL_NUL_BIT  2
`define AFC_CTRL_START    8
`define AFC_CTRL_RESET    2'h1

// Framing mode select values
`define AFC_MODE_PLAIN    2'h1
`define AFC_MODE_ESCAPED  2'h2

// Status bits
`define AFC_ST_TX_BUSY    0
`define AFC_ST_RX_READY   1
`define AFC_ST_CK_ERR     2
`define AFC_ST_OVERRUN    3
`define AFC_ST_TX_DONE    4
`define AFC_ST_STAT_SEEN  5

// Framing bytes
`define AFC_DELIM         8'h7E
`define AFC_ESC           8'h7D
`define AFC_XON           8'h11
`define AFC_XOFF          8'h13
`define AFC_ESC_XOR       8'h20
`define AFC_CK_GOOD       8'hFF
`define AFC_NUL           8'h00
`define AFC_TYPE_STATUS   8'h8A

// Buffer geometry
`define AFC_BUF_DEPTH     16'h0040
`define AFC_BUF_AW        6

`endif

// ===== afc_chk.sv
`timescale 1ns/1ps
module afc_chk
(
	input wire        core_clk,
	input wire        arst_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  tx_byte,
	input wire        tx_valid,
	input wire        tx_ready,
	input wire [7:0]  rx_byte,
	input wire        rx_valid
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// Bus answers and error flag
	AST_PREADY_HIGH: assert property (pready)
		else $error("pready low");
	AST_ERR_UNMAPPED: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
		else $error("no slave error on unmapped address");
	AST_ERR_MAPPED: assert property (psel && penable
		&& paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18} |-> !pslverr)
		else $error("slave error on mapped address");
	AST_ERR_ACCESS: assert property (!(psel && penable) |-> !pslverr)
		else $error("slave error outside access phase");
	// Read data only moves on a setup cycle, so software never sees it shift
	AST_PRDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved without setup");
	// Link byte held until taken; every frame opens with the delimiter
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("link byte dropped before accepted");
	AST_TX_START: assert property ($rose(tx_valid) |-> tx_byte == 8'h7E)
		else $error("frame did not open with delimiter");
	// Checked during reset itself, so no disable here
	AST_RST_VAL: assert property (disable iff (1'b0) !arst_n |-> !tx_valid && prdata == 32'h0)
		else $error("outputs not cleared in reset");

	COV_TX_BYTE: cover property (tx_valid && tx_ready);
	COV_TX_STALL: cover property (tx_valid && !tx_ready);
	COV_RX_BYTE: cover property (rx_valid);
	COV_BUS_ERR: cover property (pslverr);
endmodule // afc_chk

// ===== afc_dev_model.sv
`timescale 1ns/1ps
module afc_dev_model
(
	input  wire       core_clk,
	input  wire       arst_n,
	input  wire [7:0] tx_byte,
	input  wire       tx_valid,
	output reg        tx_ready,
	output reg  [7:0] rx_byte,
	output reg        rx_valid
);
	logic [7:0] got [$];
	bit         slow;
	int         tick;

	initial
	begin
		tx_ready = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		slow = 1'b0;
		tick = 0;
	end

	// Taker; slow mode stalls two cycles of three to stress the hold
	always @(posedge core_clk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		tick <= tick + 1;
		tx_ready <= arst_n && (!slow || tick % 3 == 0);
	end

	// Callers hand frames one byte per call, with sum and escapes already applied
	task automatic send(input logic [7:0] b);
		@(posedge core_clk);
		rx_byte <= b;
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_byte <= ~b; // Idle line shows no stale byte
		rx_valid <= 1'b0;
	endtask

	// Three-byte answer frame in plain framing, sum formed here
	task automatic reply(input logic [7:0] typ, input logic [7:0] id, input logic [7:0] pay);
		logic [7:0] s;
		s = 8'hFF - typ - id - pay;
		send(8'h7E);
		send(8'h00);
		send(8'h03);
		send(typ);
		send(id);
		send(pay);
		send(s);
	endtask
endmodule // afc_dev_model

// ===== tb.sv
`timescale 1ns/1ps
`include "afc_defs.vh"
module tb;
	logic        core_clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [7:0]  tx_byte;
	wire         tx_valid;
	wire         tx_ready;
	wire  [7:0]  rx_byte;
	wire         rx_valid;
	int          n_fail;
	int          cmp_count;
	int          cyc;
	logic        bus_err;

	afc_host i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_byte(rx_byte), .rx_valid(rx_valid));
	afc_dev_model i_dev (.core_clk(core_clk), .arst_n(arst_n), .tx_byte(tx_byte),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits on pready, never on an assumed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_fail++;
		q = prdata;
		bus_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	// Load, start, collect the wire bytes, then expect done and clear it
	task automatic tx_frame(input logic [31:0] ctrl, input logic [7:0] d [$],
		input logic [7:0] e [$]);
		int n;
		n = 0;
		i_dev.got.delete();
		wr(`AFC_REG_CTRL, ctrl);
		wr(`AFC_REG_TX_LEN, 32'h0);
		foreach (d[i])
			wr(`AFC_REG_TX_DATA, {24'h0, d[i]});
		wr(`AFC_REG_TX_LEN, d.size());
		wr(`AFC_REG_CTRL, ctrl | 32'h100);
		while (i_dev.got.size() < e.size() && n < 2000)
		begin
			@(posedge core_clk);
			n++;
		end
		check(i_dev.got.size(), e.size());
		foreach (e[i])
			check(i_dev.got[i], e[i]);
		rdc(`AFC_REG_STATUS, 32'h10);
		wr(`AFC_REG_STATUS, 32'h3E);
	endtask

	task automatic rx_frame(input logic [7:0] f [$], input logic [31:0] st);
		foreach (f[i])
			i_dev.send(f[i]);
		repeat (3) @(posedge core_clk);
		rdc(`AFC_REG_STATUS, st);
	endtask

	task automatic t_reset;
		logic [31:0] q;
		rdc(`AFC_REG_CTRL, 32'h1);
		rdc(`AFC_REG_STATUS, 32'h0);
		apb(1'b0, 8'h40, 32'h0, q);
		check({31'h0, bus_err}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_tx_plain;
		tx_frame(32'h1, '{8'h08, 8'h01, 8'h4E, 8'h4A, 8'hFF},
			'{8'h7E, 8'h00, 8'h05, 8'h08, 8'h01, 8'h4E, 8'h4A, 8'hFF, 8'h5F});
		tx_frame(32'h5, '{8'h08, 8'h01, 8'h4E, 8'h49},
			'{8'h7E, 8'h00, 8'h05, 8'h08, 8'h01, 8'h4E, 8'h49, 8'h00, 8'h5F});
		tx_frame(32'h1, '{8'h23, 8'h11}, '{8'h7E, 8'h00, 8'h02, 8'h23, 8'h11, 8'hCB});
		tx_frame(32'h1, '{8'h09, 8'h02, 8'h4E, 8'h4A},
			'{8'h7E, 8'h00, 8'h04, 8'h09, 8'h02, 8'h4E, 8'h4A, 8'h5C});
		tx_frame(32'h1, '{8'h10, 8'h03, 8'h41},
			'{8'h7E, 8'h00, 8'h03, 8'h10, 8'h03, 8'h41, 8'hAB});
		$display("test tx plain done");
	endtask

	// Slow taker, so escape pairs must survive stalls
	task automatic t_tx_esc;
		i_dev.slow = 1'b1;
		tx_frame(32'h2, '{8'h23, 8'h11, 8'h7E, 8'h7D, 8'h13}, '{8'h7E, 8'h00, 8'h05, 8'h23,
			8'h7D, 8'h31, 8'h7D, 8'h5E, 8'h7D, 8'h5D, 8'h7D, 8'h33, 8'hBD});
		i_dev.slow = 1'b0;
		$display("test tx escaped done");
	endtask

	task automatic t_rx_plain;
		wr(`AFC_REG_CTRL, 32'h1);
		rx_frame('{8'h55, 8'hAA, 8'h7E, 8'h00, 8'h02, 8'h7D, 8'h31, 8'h51}, 32'h2);
		rdc(`AFC_REG_RX_LEN, 32'h2);
		rdc(`AFC_REG_RX_INFO, 32'h317D);
		rdc(`AFC_REG_RX_DATA, 32'h7D);
		rdc(`AFC_REG_RX_DATA, 32'h31);
		wr(`AFC_REG_STATUS, 32'h3E);
		$display("test rx plain done");
	endtask

	task automatic t_rx_esc;
		wr(`AFC_REG_CTRL, 32'h2);
		rx_frame('{8'h7E, 8'h00, 8'h02, 8'h23, 8'h7D, 8'h31, 8'hCB}, 32'h2);
		rdc(`AFC_REG_RX_DATA, 32'h23);
		rdc(`AFC_REG_RX_DATA, 32'h11);
		wr(`AFC_REG_STATUS, 32'h3E);
		rx_frame('{8'h7E, 8'h00, 8'h02, 8'h23, 8'h11, 8'h00}, 32'h4);
		wr(`AFC_REG_STATUS, 32'h3E);
		rx_frame('{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h00, 8'h75}, 32'h22);
		rdc(`AFC_REG_RX_INFO, 32'h008A);
		$display("test rx escaped done");
	endtask

	// Every answer kind from the radio lands with its type, id and length
	task automatic t_rx_kinds;
		logic [7:0] k [$];
		k = '{8'h88, 8'h97, 8'h8B, 8'h90, 8'h91, 8'h94, 8'h95};
		wr(`AFC_REG_CTRL, 32'h1);
		wr(`AFC_REG_STATUS, 32'h3E);
		foreach (k[i])
		begin
			i_dev.reply(k[i], 8'h2C, 8'h55);
			repeat (3) @(posedge core_clk);
			rdc(`AFC_REG_STATUS, 32'h2);
			rdc(`AFC_REG_RX_LEN, 32'h3);
			rdc(`AFC_REG_RX_INFO, {16'h0, 8'h2C, k[i]});
			rdc(`AFC_REG_RX_DATA, {24'h0, k[i]});
			wr(`AFC_REG_STATUS, 32'h3E);
		end
		$display("test rx kinds done");
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Hang guard well above the several hundred cycles the tests need
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	initial
	begin
		n_fail = 0;
		cmp_count = 0;
		cyc = 0;
		// Scheduled so the reset edge reaches flops already waiting on it
		arst_n <= 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_tx_plain();
		t_tx_esc();
		t_rx_plain();
		t_rx_esc();
		t_rx_kinds();
		wrap_up();
	end
endmodule // tb

bind afc_host afc_chk i_chk (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
